// ==== rtl/dbip_map.vh ====
// Constants for the parallel pixel port: strap codes, formats, field positions
`ifndef DBIP_MAP_VH
`define DBIP_MAP_VH
// ****************************************
// Interface mode strap codes
// ****************************************
`define DBIP_IM_BUS18 3'h0
`define DBIP_IM_BUS9 3'h1
`define DBIP_IM_BUS16 3'h2
// ****************************************
// Pixel format codes
// ****************************************
`define DBIP_FMT_16BPP 3'h5
`define DBIP_FMT_18BPP 3'h6
// ****************************************
// Bus widths and field positions
// ****************************************
`define DBIP_DB_W 18
`define DBIP_COMP_W 6
`define DBIP_BYTE_MSB 7
`define DBIP_HI_MSB 15
`define DBIP_HI_LSB 10
`define DBIP_LO_MSB 7
`define DBIP_LO_LSB 2
`define DBIP_NINE_MSB 8
`define DBIP_RED_MSB 17
`define DBIP_RED_LSB 12
`define DBIP_GRN_MSB 11
`define DBIP_GRN_LSB 6
`define DBIP_BLU_MSB 5
`define DBIP_BLU_LSB 0
// ****************************************
// Synchroniser width: cs, rs, wr, rd, data, straps
// ****************************************
`define DBIP_SYNC_W 25
`endif

// ==== rtl/dbip_sync.v ====
// Two-flop synchroniser for the pin inputs of the parallel pixel port
`timescale 1ns/10ps
`default_nettype none
module dbip_sync
#(
  parameter WIDTH = 25,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
)
(
  input wire ref_clk_i,
  input wire rst_b_i,
  input wire [WIDTH-1:0] async_i,
  output reg [WIDTH-1:0] sync_o
);
  // First stage, read only by the second
  reg [WIDTH-1:0] meta_r;

  // ****************************************
  // Synchroniser stages
  // ****************************************
  // Two flops in series
  always @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      meta_r <= RST_VAL;
      sync_o <= RST_VAL;
    end
    else
    begin
      meta_r <= async_i;
      sync_o <= meta_r;
    end
  end
endmodule
`default_nettype wire

// ==== rtl/dbip_port.v ====
// Device side of the parallel pixel host port (18, 16 and 9 bit buses)
// Overview of operation
// - Straps 000: 18-bit bus, bytes on DB7..0
// - 18-bit bus 18bpp: one pixel per transfer
// - Straps 010: 16-bit bus, bytes on DB7..0
// - 16-bit bus 16bpp: 5-6-5 pixel per transfer
// - 16-bit 18bpp: two pixels in three transfers
// - Straps 001: 9-bit bus, pixel in two
`timescale 1ns/10ps
`default_nettype none
`include "dbip_map.vh"
module dbip_port
(
  input wire ref_clk_i,
  input wire rst_b_i,
  input wire cs_b_i,
  input wire register_select_i,
  input wire wr_b_i,
  input wire rd_b_i,
  input wire [17:0] db_i,
  input wire [2:0] interface_mode_straps_i,
  input wire [2:0] pixel_format_i,
  input wire data_format_ordering_bit_i,
  input wire mem_access_i,
  input wire [7:0] rd_byte_i,
  input wire [17:0] rd_pix_i,
  output reg [17:0] db_o,
  output reg db_oe_o,
  output reg cmd_valid_o,
  output reg [7:0] cmd_byte_o,
  output reg param_valid_o,
  output reg [7:0] param_byte_o,
  output reg pix_valid_o,
  output reg [17:0] pix_data_o,
  output reg rd_next_o
);
  // Transfer sequence states within a pixel group
  localparam [1:0] SEQ_T1 = 2'b00;
  localparam [1:0] SEQ_T2 = 2'b01;
  localparam [1:0] SEQ_T3 = 2'b10;

  // Synchronised pin copies
  wire [`DBIP_SYNC_W-1:0] sync_w;
  wire cs_b_s;
  wire rs_s;
  wire wr_b_s;
  wire rd_b_s;
  wire [17:0] db_s;
  wire [2:0] im_s;
  // Previous strobe levels for edge detection
  reg wr_b_d_r;
  reg rd_b_d_r;
  reg cs_b_d_r;
  // Sequence state and partial pixel hold
  reg [1:0] seq_r;
  reg [11:0] hold_r;
  reg [17:0] sav_r;
  // Decoded transfer events
  wire wr_rise;
  wire rd_fall;
  wire rd_rise;
  wire is_bus16;
  wire is_bus9;
  wire is_bus18;
  wire fmt18;
  wire data_format_ordering_bit;
  // Write word split into ordered components
  wire [5:0] wr_first;
  wire [5:0] wr_second;
  // Read word built for the current transfer
  reg [17:0] rd_word;
  reg rd_pulse;

  // ****************************************
  // Pin synchronisation
  // ****************************************
  dbip_sync
  #(
    .WIDTH(`DBIP_SYNC_W),
    .RST_VAL({3'h0, 18'h00000, 4'hF})
  )
  u_sync
  (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .async_i({interface_mode_straps_i, db_i, cs_b_i, register_select_i, wr_b_i, rd_b_i}),
    .sync_o(sync_w)
  );

  assign im_s = sync_w[24:22];
  assign db_s = sync_w[21:4];
  assign cs_b_s = sync_w[3];
  assign rs_s = sync_w[2];
  assign wr_b_s = sync_w[1];
  assign rd_b_s = sync_w[0];

  // Mode decode
  assign is_bus18 = (im_s == `DBIP_IM_BUS18);
  assign is_bus16 = (im_s == `DBIP_IM_BUS16);
  assign is_bus9 = (im_s == `DBIP_IM_BUS9);
  assign fmt18 = (pixel_format_i == `DBIP_FMT_18BPP);
  assign data_format_ordering_bit = data_format_ordering_bit_i;

  // Write rise and read fall qualified by chip select, read rise not
  assign wr_rise = wr_b_s && !wr_b_d_r && !cs_b_d_r;
  assign rd_fall = !rd_b_s && rd_b_d_r && !cs_b_s;
  assign rd_rise = rd_b_s && !rd_b_d_r;

  // Component order on the 16-bit bus for 18bpp
  assign wr_first = data_format_ordering_bit ? db_s[`DBIP_LO_MSB:`DBIP_LO_LSB] : db_s[`DBIP_HI_MSB:`DBIP_HI_LSB];
  assign wr_second = data_format_ordering_bit ? db_s[`DBIP_HI_MSB:`DBIP_HI_LSB] : db_s[`DBIP_LO_MSB:`DBIP_LO_LSB];

  // Place two components onto the 16-bit bus lanes
  function [17:0] place16;
    input order;
    input [5:0] first;
    input [5:0] second;
    begin
      if (order)
        place16 = {2'b00, second, 2'b00, first, 2'b00};
      else
        place16 = {2'b00, first, 2'b00, second, 2'b00};
    end
  endfunction

  // ****************************************
  // Read word selection
  // ****************************************
  // Word to drive and whether this transfer consumes the offered pixel
  always @*
  begin
    rd_word = 18'h00000;
    rd_pulse = 1'b1;
    if (!rs_s || !mem_access_i)
    begin
      // Bytes on the low lanes only
      rd_word = {10'h000, rd_byte_i};
      rd_pulse = rs_s;
    end
    else if (is_bus18)
    begin
      rd_word = rd_pix_i;
    end
    else if (is_bus16 && !fmt18)
    begin
      rd_word = {2'b00, rd_pix_i[15:0]};
    end
    else if (is_bus16)
    begin
      case (seq_r)
        SEQ_T1:
          rd_word = place16(data_format_ordering_bit, rd_pix_i[`DBIP_RED_MSB:`DBIP_RED_LSB],
                            rd_pix_i[`DBIP_GRN_MSB:`DBIP_GRN_LSB]);
        SEQ_T2:
          rd_word = place16(data_format_ordering_bit, sav_r[`DBIP_BLU_MSB:`DBIP_BLU_LSB],
                            rd_pix_i[`DBIP_RED_MSB:`DBIP_RED_LSB]);
        SEQ_T3:
        begin
          rd_word = place16(data_format_ordering_bit, sav_r[`DBIP_GRN_MSB:`DBIP_GRN_LSB],
                            sav_r[`DBIP_BLU_MSB:`DBIP_BLU_LSB]);
          rd_pulse = 1'b0;
        end
        default:
          rd_word = 18'h00000;
      endcase
    end
    else if (is_bus9)
    begin
      // Red and top green first, rest second
      if (seq_r == SEQ_T1)
      begin
        rd_word = {9'h000, rd_pix_i[17:9]};
        rd_pulse = 1'b0;
      end
      else
      begin
        rd_word = {9'h000, rd_pix_i[8:0]};
      end
    end
    else
    begin
      // Unsupported strap setting: drive nothing useful
      rd_pulse = 1'b0;
    end
  end

  // ****************************************
  // Transfer engine
  // ****************************************
  // Captures writes, sequences pixel groups, drives read data
  always @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      wr_b_d_r <= 1'b1;
      rd_b_d_r <= 1'b1;
      cs_b_d_r <= 1'b1;
      seq_r <= SEQ_T1;
      hold_r <= 12'h000;
      sav_r <= 18'h00000;
      db_o <= 18'h00000;
      db_oe_o <= 1'b0;
      cmd_valid_o <= 1'b0;
      cmd_byte_o <= 8'h00;
      param_valid_o <= 1'b0;
      param_byte_o <= 8'h00;
      pix_valid_o <= 1'b0;
      pix_data_o <= 18'h00000;
      rd_next_o <= 1'b0;
    end
    else
    begin
      wr_b_d_r <= wr_b_s;
      rd_b_d_r <= rd_b_s;
      cs_b_d_r <= cs_b_s;
      cmd_valid_o <= 1'b0;
      param_valid_o <= 1'b0;
      pix_valid_o <= 1'b0;
      rd_next_o <= 1'b0;
      // Write transfer
      if (wr_rise)
      begin
        if (!rs_s)
        begin
          // Command byte restarts any pixel group
          cmd_valid_o <= 1'b1;
          cmd_byte_o <= db_s[`DBIP_BYTE_MSB:0];
          seq_r <= SEQ_T1;
        end
        else if (!mem_access_i)
        begin
          // Parameter byte
          param_valid_o <= 1'b1;
          param_byte_o <= db_s[`DBIP_BYTE_MSB:0];
        end
        else if (is_bus18)
        begin
          pix_valid_o <= 1'b1;
          pix_data_o <= db_s;
        end
        else if (is_bus16 && !fmt18)
        begin
          pix_valid_o <= 1'b1;
          pix_data_o <= {2'b00, db_s[15:0]};
        end
        else if (is_bus16)
        begin
          case (seq_r)
            SEQ_T1:
            begin
              hold_r <= {wr_first, wr_second};
              seq_r <= SEQ_T2;
            end
            SEQ_T2:
            begin
              pix_valid_o <= 1'b1;
              pix_data_o <= {hold_r, wr_first};
              hold_r <= {wr_second, 6'h00};
              seq_r <= SEQ_T3;
            end
            default:
            begin
              pix_valid_o <= 1'b1;
              pix_data_o <= {hold_r[11:6], wr_first, wr_second};
              seq_r <= SEQ_T1;
            end
          endcase
        end
        else if (is_bus9)
        begin
          if (seq_r == SEQ_T1)
          begin
            hold_r <= {3'b000, db_s[`DBIP_NINE_MSB:0]};
            seq_r <= SEQ_T2;
          end
          else
          begin
            pix_valid_o <= 1'b1;
            pix_data_o <= {hold_r[8:0], db_s[`DBIP_NINE_MSB:0]};
            seq_r <= SEQ_T1;
          end
        end
      end
      // Read transfer start: drive the bus
      if (rd_fall)
      begin
        db_o <= rd_word;
        db_oe_o <= 1'b1;
      end
      else if (rd_rise || cs_b_s)
      begin
        db_oe_o <= 1'b0;
      end
      // Read transfer end: advance the group
      if (rd_rise && db_oe_o)
      begin
        rd_next_o <= rd_pulse;
        if (rs_s && mem_access_i)
        begin
          sav_r <= rd_pix_i;
          if (is_bus16 && fmt18)
            seq_r <= (seq_r == SEQ_T1) ? SEQ_T2 : ((seq_r == SEQ_T2) ? SEQ_T3 : SEQ_T1);
          else if (is_bus9)
            seq_r <= (seq_r == SEQ_T1) ? SEQ_T2 : SEQ_T1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb/dbip_port_asserts.sv ====
// Checker on the pins and pulses of the pixel port
`timescale 1ns/10ps
`default_nettype none
module dbip_port_asserts
(
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic cs_b_i,
  input wire logic register_select_i,
  input wire logic wr_b_i,
  input wire logic rd_b_i,
  input wire logic db_oe_o,
  input wire logic cmd_valid_o,
  input wire logic param_valid_o,
  input wire logic pix_valid_o,
  input wire logic rd_next_o
);
  default clocking dc @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_b_i);
  // Write strobe released while selected
  sequence wr_done_s;
    $rose(wr_b_i) && !cs_b_i;
  endsequence
  sequence rd_open_s;
    $fell(rd_b_i) && !cs_b_i;
  endsequence
  sequence rd_close_s;
    $rose(rd_b_i) && !cs_b_i;
  endsequence
  cmd_pulse_a: assert property (wr_done_s ##0 !register_select_i |-> ##[2:5] cmd_valid_o)
    else $error("command pulse missing");
  rs_high_a: assert property (wr_done_s ##0 register_select_i |-> ##1 (!cmd_valid_o)[*5])
    else $error("data write taken as command");
  valid_single_a: assert property ((cmd_valid_o || param_valid_o || pix_valid_o) |=>
    !(cmd_valid_o || param_valid_o || pix_valid_o))
    else $error("valid pulse too long");
  valid_excl_a: assert property ($onehot0({cmd_valid_o, param_valid_o, pix_valid_o}))
    else $error("two valid pulses at once");
  cs_quiet_a: assert property (cs_b_i[*8] |-> !cmd_valid_o && !pix_valid_o && !db_oe_o)
    else $error("activity while deselected");
  oe_on_a: assert property (rd_open_s |-> ##[2:5] db_oe_o)
    else $error("bus not driven on read");
  oe_off_a: assert property (rd_close_s |-> ##[2:5] !db_oe_o)
    else $error("bus not released after read");
  oe_idle_a: assert property (rd_b_i[*6] |-> !db_oe_o)
    else $error("bus driven without read");
  next_pulse_a: assert property (rd_next_o |-> !db_oe_o ##1 !rd_next_o)
    else $error("bad read advance pulse");
  cmd_only_a: assert property (wr_done_s ##0 !register_select_i |->
    ##1 (!param_valid_o && !pix_valid_o)[*5])
    else $error("command write taken as data");
endmodule
bind dbip_port dbip_port_asserts chk_u (.ref_clk_i, .rst_b_i, .cs_b_i, .register_select_i,
  .wr_b_i, .rd_b_i, .db_oe_o, .cmd_valid_o, .param_valid_o, .pix_valid_o, .rd_next_o);
`default_nettype wire

// ==== tb/dbip_host.sv ====
// Host model that drives the strobes and bus of the pixel port
`timescale 1ns/10ps
`default_nettype none
module dbip_host
(
  input wire logic ref_clk_i,
  input wire logic [17:0] dev_db_i,
  input wire logic dev_oe_i,
  output logic cs_b_o,
  output logic rs_o,
  output logic wr_b_o,
  output logic rd_b_o,
  output logic [17:0] db_o
);
  initial
  begin
    cs_b_o = 1'b1;
    rs_o = 1'b0;
    wr_b_o = 1'b1;
    rd_b_o = 1'b1;
    db_o = 18'h00000;
  end
  // Strobe low 4 cycles, data held past the rising edge
  task automatic wr(input logic cs, input logic rs, input logic [17:0] d);
    cs_b_o <= cs;
    rs_o <= rs;
    db_o <= d;
    wr_b_o <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    wr_b_o <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    cs_b_o <= 1'b1;
    db_o <= ~d;
    repeat (2) @(posedge ref_clk_i);
  endtask
  // Read: sample only a driven bus
  task automatic rd(input logic rs, output logic [17:0] q);
    cs_b_o <= 1'b0;
    rs_o <= rs;
    rd_b_o <= 1'b0;
    repeat (6) @(posedge ref_clk_i);
    q = dev_oe_i ? dev_db_i : ~dev_db_i;
    rd_b_o <= 1'b1;
    repeat (5) @(posedge ref_clk_i);
    cs_b_o <= 1'b1;
    @(posedge ref_clk_i);
  endtask
endmodule
`default_nettype wire

// ==== tb/dbip_port_bench.sv ====
// Self-checking bench for the parallel pixel port
`timescale 1ns/10ps
`default_nettype none
module dbip_port_bench;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [2:0] straps = 3'h0;
  logic [2:0] fmt = 3'h6;
  logic data_format_ordering_bit = 1'b0;
  logic mem = 1'b0;
  logic [7:0] rbyte = 8'h00;
  logic [17:0] rpix = 18'h00000;
  logic cs_b, rs, wr_b, rd_b, oe, cv, pv, xv, nx;
  logic [17:0] dbh, dbd, pd, lastpix;
  logic [7:0] cb, pb;
  int miscompares = 0;
  int samples_checked = 0;
  int ncmd = 0;
  int npix = 0;
  int nnext = 0;
  int npar = 0;
  always #4 clk = ~clk;
  dbip_host host_u (.ref_clk_i(clk), .dev_db_i(dbd), .dev_oe_i(oe), .cs_b_o(cs_b),
    .rs_o(rs), .wr_b_o(wr_b), .rd_b_o(rd_b), .db_o(dbh));
  dbip_port dut_u (.ref_clk_i(clk), .rst_b_i(rst_b), .cs_b_i(cs_b),
    .register_select_i(rs), .wr_b_i(wr_b), .rd_b_i(rd_b), .db_i(dbh),
    .interface_mode_straps_i(straps), .pixel_format_i(fmt),
    .data_format_ordering_bit_i(data_format_ordering_bit), .mem_access_i(mem), .rd_byte_i(rbyte),
    .rd_pix_i(rpix), .db_o(dbd), .db_oe_o(oe), .cmd_valid_o(cv), .cmd_byte_o(cb),
    .param_valid_o(pv), .param_byte_o(pb), .pix_valid_o(xv), .pix_data_o(pd),
    .rd_next_o(nx));
  // Pulse counters and last pixel
  always @(posedge clk)
  begin
    if (cv === 1'b1)
      ncmd++;
    if (xv === 1'b1)
      npix++;
    if (xv === 1'b1)
      lastpix = pd;
    if (nx === 1'b1)
      nnext++;
    if (pv === 1'b1)
      npar++;
  end
  task automatic chk(input string nm, input logic [17:0] e, input logic [17:0] g);
    samples_checked++;
    if (g !== e)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic px(input logic [17:0] d);
    host_u.wr(1'b0, 1'b1, d);
  endtask
  task automatic give_verdict;
    $display("checked %0d mismatched %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Watchdog
  initial
  begin
    #100000;
    miscompares++;
    give_verdict();
  end
  initial
  begin
    logic [17:0] q;
    logic [17:0] wv [0:2];
    logic [35:0] pp;
    int n0;
    pp = 36'h9A5B6C3D2;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    host_u.wr(1'b0, 1'b0, 18'h3FFA5);
    chk("cmd18", 18'h000A5, {10'h0, cb});
    host_u.wr(1'b0, 1'b1, 18'h2FF3C);
    chk("param18", 18'h0003C, {10'h0, pb});
    chk("paramcount", 18'h00001, 18'(npar));
    n0 = ncmd;
    host_u.wr(1'b1, 1'b0, 18'h00011);
    chk("deselected", 18'(n0), 18'(ncmd));
    mem <= 1'b1;
    px(18'h2B3C5);
    chk("pix18", 18'h2B3C5, lastpix);
    chk("pixnotparam", 18'h00001, 18'(npar));
    rbyte <= 8'h5A;
    n0 = nnext;
    host_u.rd(1'b0, q);
    chk("rdbyte", 18'h0005A, {10'h0, q[7:0]});
    chk("bytenext", 18'(n0), 18'(nnext));
    rpix <= 18'h1D2E3;
    n0 = nnext;
    host_u.rd(1'b1, q);
    chk("rdpix", 18'h1D2E3, q);
    chk("rdnext", 18'(n0 + 1), 18'(nnext));
    $display("test bus18 done");
    straps <= 3'h2;
    fmt <= 3'h5;
    host_u.wr(1'b0, 1'b0, 18'h0FF77);
    chk("cmd16", 18'h00077, {10'h0, cb});
    px(18'h3BEEF);
    chk("pix16", 18'h0BEEF, lastpix);
    rpix <= 18'h2A1B2;
    host_u.rd(1'b1, q);
    chk("rd16", 18'h0A1B2, q);
    fmt <= 3'h6;
    for (int d = 0; d < 2; d++)
    begin
      data_format_ordering_bit <= d[0];
      px(18'h3FFFF);
      host_u.wr(1'b0, 1'b0, 18'h0002C);
      n0 = npix;
      for (int k = 0; k < 3; k++)
      begin
        wv[k] = d ? {2'h0, pp[29-12*k -: 6], 2'h0, pp[35-12*k -: 6], 2'h0}
          : {2'h0, pp[35-12*k -: 6], 2'h0, pp[29-12*k -: 6], 2'h0};
        px(wv[k]);
        chk("packcount", 18'(n0 + k), 18'(npix));
        if (k > 0)
          chk("packpix", pp[35-18*(k-1) -: 18], lastpix);
      end
      // Read the same two pixels back, second offered after the first advance
      rpix <= pp[35:18];
      n0 = nnext;
      for (int k = 0; k < 3; k++)
      begin
        host_u.rd(1'b1, q);
        chk("packread", wv[k], q);
        rpix <= pp[17:0];
      end
      chk("packnext", 18'(n0 + 2), 18'(nnext));
    end
    $display("test bus16 done");
    straps <= 3'h1;
    host_u.wr(1'b0, 1'b0, 18'h001C3);
    chk("cmd9", 18'h000C3, {10'h0, cb});
    px({9'h0, pp[17:9]});
    px({9'h0, pp[8:0]});
    chk("pix9", pp[17:0], lastpix);
    n0 = nnext;
    host_u.rd(1'b1, q);
    chk("rd9first", {9'h000, pp[17:9]}, q);
    host_u.rd(1'b1, q);
    chk("rd9second", {9'h000, pp[8:0]}, q);
    chk("rd9next", 18'(n0 + 1), 18'(nnext));
    straps <= 3'h4;
    n0 = npix;
    px(18'h12345);
    chk("badmode", 18'(n0), 18'(npix));
    $display("test bus9 done");
    give_verdict();
  end
endmodule
`default_nettype wire
